// ---- tap_device.sv ----
`timescale 1ns/1ps
`include "tap_defines.svh"
// Behaviour
// R01: system asserts both resets at power-up
// R02: device reset core, test reset emulation
// R03: test reset sampled on running test clock
// R04: core boots once device reset released
// R05: held test reset keeps emulation idle only
// R06: variant valid only after device reset release
// R07: other identification fields independent of reset
// R08: undriven test reset defaults to asserted
// R09: passive controller asserts then releases reset
// R10: mode pins latched on test reset rise
// R11: latched pins choose scan or emulation
// R12: identification register read-only at fixed address
// R13: variant, part, manufacturer field layout
// R14: bit zero always reads one
// R15: full 32-bit word every read
// R16: writes to identification register ignored
module tap_device (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  tap_if.device link,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic core_run_o,
  output logic emu_in_reset_o,
  output logic scan_mode_o,
  output logic emu_mode_o
);
  // ------------------------------------------------------------
  // pin filters
  // ------------------------------------------------------------
  logic tck_rise;
  logic trst_ff;
  logic drst_ff;
  logic [1:0] mode_lvl_ff;
  logic trst_pend_ff;
  logic trst_q_ff;
  logic dev_rel_ff;
  logic [1:0] mode_ff;
  logic [31:0] id_word;
  logic hit;

  // test clock: only its filtered rising edges are used
  tap_pin_filter #(
    .WIDTH(1)
  ) tck_filter_inst (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .pin_i(link.test_clock_input),
    .level_o(),
    .rise_o(tck_rise)
  );

  // test reset; stages clear low, so it reads asserted
  tap_pin_filter #(
    .WIDTH(1)
  ) trst_filter_inst (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .pin_i(link.test_reset_n_wire), // R08
    .level_o(trst_ff),
    .rise_o()
  );

  // device reset, low while the core is held
  tap_pin_filter #(
    .WIDTH(1)
  ) drst_filter_inst (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .pin_i(link.device_reset_n),
    .level_o(drst_ff),
    .rise_o()
  );

  // mode select pins, latched later on test reset release
  tap_pin_filter #(
    .WIDTH(2)
  ) mode_filter_inst (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .pin_i(link.test_mode_select_pins),
    .level_o(mode_lvl_ff),
    .rise_o()
  );

  // ------------------------------------------------------------
  // resets and mode latch
  // ------------------------------------------------------------
  // test reset taken only on a test clock rising edge
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      trst_pend_ff <= 1'b0;
    end else if (tck_rise) begin
      trst_pend_ff <= trst_ff; // R03
    end
  end

  // flag first test reset rise after device reset release; pins latch on that rise
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      trst_q_ff <= 1'b0;
      dev_rel_ff <= 1'b0;
      mode_ff <= `MODE_SEL_RST;
    end else begin
      trst_q_ff <= trst_pend_ff;
      if (!drst_ff) begin
        dev_rel_ff <= 1'b0;
      end else if (trst_pend_ff & ~trst_q_ff) begin
        dev_rel_ff <= 1'b1;
        if (!dev_rel_ff) mode_ff <= mode_lvl_ff; // R10
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      core_run_o <= 1'b0;
      emu_in_reset_o <= 1'b1;
      scan_mode_o <= 1'b0;
      emu_mode_o <= 1'b0;
    end else begin
      core_run_o <= drst_ff; // R02 R04
      emu_in_reset_o <= ~trst_pend_ff; // R02 R05
      scan_mode_o <= trst_pend_ff &
        (mode_ff == tap_pkg::MODE_BOUNDARY_SCAN); // R11
      emu_mode_o <= trst_pend_ff &
        (mode_ff == tap_pkg::MODE_EMULATION); // R11
    end
  end

  // ------------------------------------------------------------
  // identification register
  // ------------------------------------------------------------
  always_comb begin
    id_word = 32'h0;
    id_word[`ID_VARIANT_HI:`ID_VARIANT_LO] = drst_ff ?
      `ID_VARIANT_VAL : `ID_VARIANT_UNK; // R06
    id_word[`ID_PART_HI:`ID_PART_LO] = `ID_PART_VAL; // R13 R07
    id_word[`ID_MFR_HI:`ID_MFR_LO] = `ID_MFR_VAL; // R13
    id_word[`ID_LSB_BIT] = `ID_LSB_VAL; // R14
  end

  // address decode for the one register
  assign hit = (addr_i == `ID_ADDR); // R12

  // read answer one cycle later; writes have no effect
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_o <= 32'h0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i & ~wr_en_i; // R16
      if (rd_en_i & ~wr_en_i) rdata_o <= hit ? id_word : 32'h0; // R15
    end
  end
endmodule

// ------------------------------------------------------------
// three-stage pin filter
// ------------------------------------------------------------
module tap_pin_filter #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] agree;

  // shift chain; stage one feeds only stage two
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
    end else begin
      stage1_ff <= pin_i;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // level moves only where stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      level_o <= '0;
    end else begin
      level_o <= (agree & stage3_ff) | (~agree & level_o);
    end
  end

  // per-bit agreement and rising edge of the filtered level
  assign agree = ~(stage2_ff ^ stage3_ff);
  assign rise_o = agree & stage3_ff & ~level_o;
endmodule

// ---- tap_defines.svh ----
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH
`define ID_ADDR 32'h01B3F008
`define ID_VARIANT_HI 31
`define ID_VARIANT_LO 28
`define ID_PART_HI 27
`define ID_PART_LO 12
`define ID_MFR_HI 11
`define ID_MFR_LO 1
`define ID_LSB_BIT 0
`define ID_LSB_VAL 1'h1
`define ID_PART_VAL 16'h1234 // arbitrary value
`define ID_MFR_VAL 11'h2A5 // arbitrary value
`define ID_VARIANT_VAL 4'h3 // arbitrary value
`define ID_VARIANT_UNK 4'hF // arbitrary value
`define LINK_DIV_HALF 4
`define MODE_SEL_RST 2'h0
`endif

// ---- tap_pkg.sv ----
package tap_pkg;
  // device operating mode picked by the latched select pins
  typedef enum logic [1:0] {
    MODE_EMULATION = 2'h1,
    MODE_BOUNDARY_SCAN = 2'h2
  } test_mode_t;
  // controller reset sequence
  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_WAIT_DEV = 4'h2,
    ST_RELEASE = 4'h4,
    ST_ACTIVE = 4'h8
  } ctl_state_t;
endpackage

// ---- tap_if.sv ----
`timescale 1ns/1ps
interface tap_if;
  logic test_clock_input;
  logic test_reset_n;
  logic test_reset_n_oe;
  logic [1:0] test_mode_select_pins;
  logic test_data_in;
  logic test_mode_sel_tms;
  logic device_reset_n;
  // undriven test reset reads low: internal pull down
  logic test_reset_n_wire;
  assign test_reset_n_wire = test_reset_n_oe ? test_reset_n : 1'b0;
  modport device (
    input test_clock_input, test_reset_n_wire, test_mode_select_pins,
    input test_data_in, test_mode_sel_tms, device_reset_n
  );
  modport controller (
    output test_clock_input, test_reset_n, test_reset_n_oe,
    output test_mode_select_pins, test_data_in, test_mode_sel_tms,
    output device_reset_n
  );
endinterface

// ---- tap_controller.sv ----
`timescale 1ns/1ps
`include "tap_defines.svh"
module tap_controller (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  tap_if.controller link,
  input wire logic start_i,
  input wire logic [1:0] mode_i,
  input wire logic dev_reset_i,
  output logic active_o
);
  // ------------------------------------------------------------
  // test clock divider and reset sequence
  // ------------------------------------------------------------
  logic [3:0] div_ff;
  logic tck_ff;
  logic trst_n_ff;
  logic drst_n_ff;
  logic trst_oe_ff;
  logic [1:0] mode_ff;
  tap_pkg::ctl_state_t state_ff;
  // free running test clock, also during test reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      div_ff <= 4'h0;
      tck_ff <= 1'b0;
    end else if (div_ff == 4'(`LINK_DIV_HALF - 1)) begin
      div_ff <= 4'h0;
      tck_ff <= ~tck_ff; // R03
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end
  // hold test reset, wait for device reset release, then raise test reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_ff <= tap_pkg::ST_HOLD;
      trst_n_ff <= 1'b0; // R01 R09
      drst_n_ff <= 1'b0; // R01
      trst_oe_ff <= 1'b0;
      mode_ff <= 2'h0;
      active_o <= 1'b0;
    end else begin
      mode_ff <= mode_i;
      drst_n_ff <= ~dev_reset_i; // device reset follows request
      trst_oe_ff <= (state_ff != tap_pkg::ST_HOLD); // R09
      case (state_ff)
        tap_pkg::ST_HOLD: begin
          if (start_i) state_ff <= tap_pkg::ST_WAIT_DEV;
        end
        tap_pkg::ST_WAIT_DEV: begin
          if (drst_n_ff && tck_ff) state_ff <= tap_pkg::ST_RELEASE; // R06
        end
        tap_pkg::ST_RELEASE: begin
          if (!tck_ff) begin
            trst_n_ff <= 1'b1; // R10 R09
            state_ff <= tap_pkg::ST_ACTIVE;
          end
        end
        tap_pkg::ST_ACTIVE: begin
          active_o <= 1'b1;
          if (!start_i) begin
            trst_n_ff <= 1'b0;
            active_o <= 1'b0;
            state_ff <= tap_pkg::ST_HOLD;
          end
        end
        default: state_ff <= tap_pkg::ST_HOLD;
      endcase
    end
  end
  assign link.test_clock_input = tck_ff;
  assign link.test_reset_n = trst_n_ff;
  assign link.test_reset_n_oe = trst_oe_ff;
  assign link.test_mode_select_pins = mode_ff;
  assign link.test_data_in = 1'b0;
  assign link.test_mode_sel_tms = 1'b1;
  assign link.device_reset_n = drst_n_ff;
endmodule

// ---- tap_link_asserts.sv ----
`timescale 1ns/1ps
module tap_link_asserts (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic test_clock_input,
  input wire logic test_reset_n_oe,
  input wire logic test_reset_n_wire,
  input wire logic [1:0] test_mode_select_pins,
  input wire logic device_reset_n
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // ----------------------------------------
  // link wire checks
  // ----------------------------------------
  AST_RST_BOTH_LOW:
    assert property ($fell(srst_i) |-> !device_reset_n && !test_reset_n_wire)
    else $error("resets not asserted after reset");
  AST_TCK_IDLE:
    assert property ($fell(srst_i) |-> !test_clock_input)
    else $error("test clock not idle low after reset");
  AST_UNDRIVEN_LOW:
    assert property (!test_reset_n_oe |-> !test_reset_n_wire)
    else $error("undriven test reset not low");
  AST_TCK_HIGH4:
    assert property ($rose(test_clock_input) |->
      test_clock_input [*4] ##1 !test_clock_input)
    else $error("test clock high phase wrong");
  AST_TCK_LOW4:
    assert property ($fell(test_clock_input) |->
      !test_clock_input [*4] ##1 test_clock_input)
    else $error("test clock low phase wrong");
  AST_TCK_RUNS:
    assert property (!test_reset_n_wire |-> ##[1:8] $changed(test_clock_input))
    else $error("test clock stopped during test reset");
  AST_TRST_AFTER_DEV:
    assert property ($rose(test_reset_n_wire) |-> device_reset_n)
    else $error("test reset released before device reset");
  AST_MODE_STABLE:
    assert property ($rose(test_reset_n_wire) |-> $stable(test_mode_select_pins))
    else $error("mode pins moved at test reset release");
  AST_DRIVEN_HIGH:
    assert property ($rose(test_reset_n_wire) |-> test_reset_n_oe)
    else $error("test reset high without drive");
  // scenario coverage
  cover property ($rose(test_reset_n_wire) && test_mode_select_pins == 2'h1);
  cover property ($rose(test_reset_n_wire) && test_mode_select_pins == 2'h2);
  cover property ($fell(test_reset_n_wire) && device_reset_n);
endmodule

// ---- test_port_reset_and_id_tb.sv ----
`timescale 1ns/1ps
`include "tap_defines.svh"
module test_port_reset_and_id_tb;
  logic clk_sys_i, srst_i, rd_en_i, wr_en_i, start_i, dev_reset_i;
  logic rvalid_o, core_run_o, emu_in_reset_o, scan_mode_o, emu_mode_o;
  logic active_o;
  logic [31:0] addr_i, wdata_i, rdata_o;
  logic [1:0] mode_i;
  int err_count = 0;
  int samples_checked = 0;
  localparam logic [31:0] ID =
    {`ID_VARIANT_VAL, `ID_PART_VAL, `ID_MFR_VAL, `ID_LSB_VAL};
  localparam logic [31:0] ID_RST = {`ID_VARIANT_UNK, ID[27:0]};
  tap_if link_if();
  tap_device tap_device_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .link(link_if.device), .rd_en_i(rd_en_i), .wr_en_i(wr_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .core_run_o(core_run_o),
    .emu_in_reset_o(emu_in_reset_o), .scan_mode_o(scan_mode_o),
    .emu_mode_o(emu_mode_o));
  tap_controller tap_controller_inst (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .link(link_if.controller), .start_i(start_i),
    .mode_i(mode_i), .dev_reset_i(dev_reset_i), .active_o(active_o));
  tap_link_asserts tap_link_asserts_inst (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .test_clock_input(link_if.test_clock_input),
    .test_reset_n_oe(link_if.test_reset_n_oe),
    .test_reset_n_wire(link_if.test_reset_n_wire),
    .test_mode_select_pins(link_if.test_mode_select_pins),
    .device_reset_n(link_if.device_reset_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  // one read cycle, bounded wait for the valid pulse
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    int i;
    rd_en_i = 1'h1;
    addr_i = a;
    cyc(1);
    rd_en_i = 1'h0;
    for (i = 0; i < 4 && rvalid_o !== 1'h1; i++) cyc(1);
    chk({31'h0, rvalid_o}, 32'h1, "read valid");
    chk(rdata_o, exp, "read data");
    cyc(1);
  endtask
  task automatic mode_chk(input logic s, input logic e, input logic r);
    chk({29'h0, scan_mode_o, emu_mode_o, emu_in_reset_o},
        {29'h0, s, e, r}, "mode state");
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'h0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #(50 * 3000);
    err_count++;
    end_of_test();
  end
  initial begin
    int m;
    int i;
    srst_i = 1'h1;
    rd_en_i = 1'h0;
    wr_en_i = 1'h0;
    start_i = 1'h0;
    dev_reset_i = 1'h1;
    addr_i = 32'h0;
    wdata_i = 32'h0;
    mode_i = 2'h0;
    cyc(6);
    srst_i = 1'h0;
    cyc(20);
    chk({31'h0, core_run_o}, 32'h0, "core held");
    mode_chk(1'h0, 1'h0, 1'h1);
    rd(`ID_ADDR, ID_RST);
    dev_reset_i = 1'h0;
    cyc(20);
    chk({31'h0, core_run_o}, 32'h1, "core runs");
    mode_chk(1'h0, 1'h0, 1'h1);
    rd(`ID_ADDR, ID);
    rd(`ID_ADDR + 32'h4, 32'h0);
    wr_en_i = 1'h1;
    addr_i = `ID_ADDR;
    wdata_i = ~ID;
    cyc(1);
    wr_en_i = 1'h0;
    chk({31'h0, rvalid_o}, 32'h0, "write answered");
    chk(rdata_o, 32'h0, "write moved read data");
    rd(`ID_ADDR, ID);
    for (m = 0; m < 4; m++) begin
      dev_reset_i = 1'h1;
      cyc(10);
      chk({31'h0, core_run_o}, 32'h0, "core reset");
      rd(`ID_ADDR, ID_RST);
      dev_reset_i = 1'h0;
      mode_i = m[1:0];
      start_i = 1'h1;
      for (i = 0; i < 100 && active_o !== 1'h1; i++) cyc(1);
      cyc(40);
      mode_chk(m == 2, m == 1, 1'h0);
      rd(`ID_ADDR, ID);
      start_i = 1'h0;
      cyc(40);
      mode_chk(1'h0, 1'h0, 1'h1);
    end
    end_of_test();
  end
endmodule
